// ### inc/spi_slave_consts.vh
// Constants shared by the serial slave engine and its helpers.
`ifndef SPI_SLAVE_CONSTS_VH
`define SPI_SLAVE_CONSTS_VH

// =====================================================================
// Data path widths
`define BYTE_W          8
`define BYTE_MSB        7
`define BYTE_ZERO       8'h00
`define CNT_W           3
`define CNT_ZERO        3'h0
`define CNT_ONE         3'h1
`define CNT_LAST        3'h7

// =====================================================================
// Receive FIFO shape
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define FIFO_CW         5

// =====================================================================
// Slave select mode codes {upper, lower}
`define SELMODE_3WIRE   2'h0
`define SELMODE_4WIRE   2'h1

// =====================================================================
// Flag positions in flag_clear
`define FLAG_DONE       0
`define FLAG_WRITE_COLLISION_FLAG       1
`define FLAG_MODE_FAULT_FLAG       2
`define FLAG_OVRN       3
`define FLAG_W          4

// =====================================================================
// Synchronised pin positions
`define PIN_SCK         0
`define PIN_MOSI        1
`define PIN_SEL         2
`define PIN_W           3

`endif

// ### design/pin_sync.v
// Two-stage synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    // Clock, reset and enable
    input  wire         clk,
    input  wire         rstn,
    input  wire         ce,
    // Pins in and synchronised levels out
    input  wire [W-1:0] pin,
    output reg  [W-1:0] level
);
    reg [W-1:0] stage1;

    // =================================================================
    // Synchroniser
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= {W{1'b0}};
            level  <= {W{1'b0}};
        end else if (ce) begin
            stage1 <= pin;
            level  <= stage1;
        end
    end
endmodule

// ### design/rx_fifo.v
// Receive FIFO with registered output stage and valid/ready on both sides.
`timescale 1ns/1ps
`include "spi_slave_consts.vh"
module rx_fifo #(
    parameter W  = `BYTE_W,
    parameter D  = `FIFO_DEPTH,
    parameter AW = `FIFO_AW,
    parameter CW = `FIFO_CW
) (
    // Clock, reset and enable
    input  wire         clk,
    input  wire         rstn,
    input  wire         ce,
    input  wire         flush,
    // Filling side
    input  wire         in_valid,
    input  wire [W-1:0] in_data,
    output wire         in_ready,
    // Draining side
    output reg          out_valid,
    output reg  [W-1:0] out_data,
    input  wire         out_ready
);
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [CW-1:0] count;
    wire         push;
    wire         pop;
    wire         head_free;

    // The output stage holds a word too, so it counts toward the depth.
    assign in_ready  = (count != D[CW-1:0]) &&
                       !((count == D[CW-1:0] - 1'b1) && out_valid && !out_ready);
    assign push      = in_valid && in_ready;
    assign head_free = !out_valid || out_ready;
    assign pop       = head_free && (count != {CW{1'b0}});

    // =================================================================
    // Storage
    always @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // =================================================================
    // Pointers, fill count and output stage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {CW{1'b0}};
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
        end else if (ce) begin
            if (flush) begin
                wr_ptr    <= {AW{1'b0}};
                rd_ptr    <= {AW{1'b0}};
                count     <= {CW{1'b0}};
                out_valid <= 1'b0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr   <= rd_ptr + 1'b1;
                    out_data <= mem[rd_ptr];
                end
                if (head_free) begin
                    out_valid <= pop;
                end
                if (push && !pop) begin
                    count <= count + 1'b1;
                end else if (pop && !push) begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule

// ### design/spi_slave_engine.v
// Serial peripheral slave engine with event flags and a receive FIFO.
// Notes on behaviour
// R1 - Slave operation whenever port enabled and master enable clear; the code leaves the slave inactive in select modes 10 and 11.
// R2 - Master drives the serial clock; bits shift in and out under it.
// R3 - Count clock edges; after eight bits set done and store the byte.
// R4 - Reading the data register returns the receive buffer.
// R5 - Slave never starts a transfer by itself.
// R6 - Data writes go to transmit buffer; empty shift register takes it at once.
// R7 - Busy shift register takes the buffered byte after the last edge.
// R8 - Select mode 01 gives 4-wire slave operation, the default.
// R9 - In 4-wire mode select low activates the slave, high deactivates.
// R10 - In 4-wire mode select falling edge clears the bit counter.
// R11 - Master lowers select two system clocks before first clock edge.
// R12 - Select mode 00 gives 3-wire operation; select input ignored.
// R13 - In 3-wire mode this must be the only slave on the bus.
// R14 - In 3-wire mode only toggling port enable clears the counter.
// R15 - Four event flags are set by hardware, cleared only by software.
// R16 - Byte done flag sets at end of every byte, in all modes; the code never sets it in select modes 10 and 11.
// R17 - Write with full transmit buffer sets collision and is dropped.
// R18 - Multi-master low select sets mode fault, clears both enables.
// R19 - Transfer into full receive buffer sets overrun, new byte lost.
// R20 - Polarity bit sets clock idle level: 0 low, 1 high.
// R21 - Phase bit: 0 samples first edge, 1 samples second edge.
// R22 - Busy bit reads 1 while a transfer is in progress.
// R23 - Bytes travel most significant bit first both ways.
// R24 - Select input is synchronised before any use.
`timescale 1ns/1ps
`include "spi_slave_consts.vh"
module spi_slave_engine (
    // Clock, reset and enable
    input  wire                clk,
    input  wire                rstn,
    input  wire                ce,
    // Control write: loads the enable, mode and clock bits below
    input  wire                ctrl_write,
    input  wire                port_enable_bit,
    input  wire                master_enable_bit,
    input  wire                clock_phase_bit,
    input  wire                clock_polarity_bit,
    input  wire                select_mode_upper_bit,
    input  wire                select_mode_lower_bit,
    // Control state as held
    output reg                 port_enable_state,
    output reg                 master_enable_state,
    // Data register write
    input  wire                tx_write,
    input  wire [`BYTE_MSB:0]  tx_data,
    // Data register read (receive buffer head)
    output wire                rx_valid,
    output wire [`BYTE_MSB:0]  rx_data,
    input  wire                rx_read,
    // Flags and status
    input  wire [`FLAG_W-1:0]  flag_clear,
    output reg                 byte_done_flag,
    output reg                 write_collision_flag,
    output reg                 mode_fault_flag,
    output reg                 receive_overrun_flag,
    output reg                 transfer_busy_bit,
    output reg                 shift_empty,
    output reg                 slave_selected,
    // Serial pins
    input  wire                sck,
    input  wire                mosi,
    input  wire                sel_n,
    output reg                 miso_out,
    output reg                 miso_oe_n
);
    reg                  phase;
    reg                  polarity;
    reg  [1:0]           sel_mode;
    wire [`PIN_W-1:0]    pins;
    reg                  sck_prev;
    reg                  sel_prev;
    reg  [`CNT_W-1:0]    bit_count;
    reg                  ending;
    reg  [`BYTE_MSB:0]   rx_shift;
    reg  [`BYTE_MSB:0]   tx_shift;
    reg                  shift_full;
    reg  [`BYTE_MSB:0]   tx_buf;
    reg                  tx_buf_full;

    wire sck_s;
    wire mosi_s;
    wire sel_s;
    wire mode_4wire;
    wire mode_3wire;
    wire slave_on;
    wire active;
    wire sck_edge;
    wire lead_edge;
    wire sample_edge;
    wire launch_edge;
    wire last_edge;
    wire sel_fall;
    wire fault;
    wire write_collision_flag_set;
    wire direct_load;
    wire ovrn_set;
    wire fifo_in_ready;
    wire [`BYTE_MSB:0] rx_byte;

    // =================================================================
    // Pin synchronisers
    pin_sync #(
        .W     (`PIN_W)
    ) u_sync (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        // Select enters inverted so the reset level of the flops matches its idle level.
        .pin   ({~sel_n, mosi, sck}),
        .level (pins)
    );

    assign sck_s  = pins[`PIN_SCK];
    assign mosi_s = pins[`PIN_MOSI];
    assign sel_s  = ~pins[`PIN_SEL]; // R24

    // =================================================================
    // Mode decode and edge detection
    assign mode_4wire = (sel_mode == `SELMODE_4WIRE); // R8
    assign mode_3wire = (sel_mode == `SELMODE_3WIRE); // R12
    assign slave_on   = port_enable_state && !master_enable_state; // R1
    // Select ignored in 3-wire mode; other codes are master-only.
    assign active     = slave_on && (mode_3wire || (mode_4wire && !sel_s)); // R9
    assign sck_edge   = (sck_s != sck_prev);
    // Leading edge leaves the idle level chosen by the polarity bit.
    assign lead_edge   = sck_edge && (sck_prev == polarity); // R20
    assign sample_edge = active && (phase ? (sck_edge && !lead_edge) : lead_edge); // R21
    assign launch_edge = active && (phase ? lead_edge : (sck_edge && !lead_edge)); // R2
    // Phase 1 ends on the eighth sample; phase 0 on the edge after it.
    assign last_edge = phase ? (sample_edge && (bit_count == `CNT_LAST)) : (launch_edge && ending); // R3
    assign sel_fall  = slave_on && mode_4wire && sel_prev && !sel_s; // R10
    assign fault     = port_enable_state && master_enable_state && mode_4wire && !sel_s; // R18
    assign rx_byte   = phase ? {rx_shift[`BYTE_MSB-1:0], mosi_s} : rx_shift;
    assign ovrn_set  = last_edge && !fifo_in_ready; // R19
    assign write_collision_flag_set  = tx_write && tx_buf_full; // R17
    assign direct_load = tx_write && !tx_buf_full && !shift_full && !transfer_busy_bit; // R6

    // =================================================================
    // Receive FIFO: the receive buffer seen by software
    rx_fifo #(
        .W         (`BYTE_W),
        .D         (`FIFO_DEPTH),
        .AW        (`FIFO_AW),
        .CW        (`FIFO_CW)
    ) u_rx (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .flush     (!port_enable_state),
        .in_valid  (last_edge && fifo_in_ready), // R3
        .in_data   (rx_byte),
        .in_ready  (fifo_in_ready),
        .out_valid (rx_valid),
        .out_data  (rx_data), // R4
        .out_ready (rx_read)
    );

    // =================================================================
    // Control state
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port_enable_state   <= 1'b0;
            master_enable_state <= 1'b0;
            phase               <= 1'b0;
            polarity            <= 1'b0;
            sel_mode            <= `SELMODE_4WIRE;
        end else if (ce) begin
            if (fault) begin
                port_enable_state   <= 1'b0; // R18
                master_enable_state <= 1'b0; // R18
            end else if (ctrl_write) begin
                port_enable_state   <= port_enable_bit;
                master_enable_state <= master_enable_bit;
                phase               <= clock_phase_bit;
                polarity            <= clock_polarity_bit;
                sel_mode            <= {select_mode_upper_bit, select_mode_lower_bit};
            end
        end
    end

    // =================================================================
    // Bit counter and shift registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_prev  <= 1'b0;
            sel_prev  <= 1'b1;
            bit_count <= `CNT_ZERO;
            ending    <= 1'b0;
            rx_shift  <= `BYTE_ZERO;
        end else if (ce) begin
            sck_prev <= sck_s;
            sel_prev <= sel_s;
            // Disabling the port is the only counter reset in 3-wire mode.
            if (!port_enable_state || sel_fall) begin // R14
                bit_count <= `CNT_ZERO; // R10
                ending    <= 1'b0;
            end else begin
                if (sample_edge) begin
                    rx_shift  <= {rx_shift[`BYTE_MSB-1:0], mosi_s}; // R23
                    bit_count <= bit_count + `CNT_ONE; // R3
                    if (!phase && bit_count == `CNT_LAST) begin
                        ending <= 1'b1;
                    end
                end
                if (last_edge) begin
                    ending <= 1'b0;
                end
            end
        end
    end

    // =================================================================
    // Transmit buffer, shift register and output pin
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_buf      <= `BYTE_ZERO;
            tx_buf_full <= 1'b0;
            tx_shift    <= `BYTE_ZERO;
            shift_full  <= 1'b0;
            miso_out    <= 1'b0;
        end else if (ce) begin
            if (!port_enable_state) begin
                tx_buf_full <= 1'b0;
                shift_full  <= 1'b0;
            end else if (direct_load) begin
                shift_full <= 1'b1; // R6
                if (phase) begin
                    tx_shift <= tx_data;
                end else begin
                    miso_out <= tx_data[`BYTE_MSB];
                    tx_shift <= {tx_data[`BYTE_MSB-1:0], 1'b0};
                end
            end else begin
                if (tx_write && !tx_buf_full) begin
                    tx_buf      <= tx_data;
                    tx_buf_full <= 1'b1;
                end
                if (last_edge) begin
                    shift_full <= tx_buf_full; // R7
                    if (tx_buf_full) begin
                        tx_buf_full <= 1'b0; // R7
                        if (phase) begin
                            tx_shift <= tx_buf;
                        end else begin
                            miso_out <= tx_buf[`BYTE_MSB];
                            tx_shift <= {tx_buf[`BYTE_MSB-1:0], 1'b0};
                        end
                    end else begin
                        tx_shift <= `BYTE_ZERO;
                    end
                end else if (launch_edge) begin
                    miso_out <= tx_shift[`BYTE_MSB]; // R23
                    tx_shift <= {tx_shift[`BYTE_MSB-1:0], 1'b0};
                end
            end
        end
    end

    // =================================================================
    // Event flags: a set in the same cycle as a clear wins
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_done_flag       <= 1'b0;
            write_collision_flag <= 1'b0;
            mode_fault_flag      <= 1'b0;
            receive_overrun_flag <= 1'b0;
        end else if (ce) begin
            byte_done_flag       <= last_edge || (byte_done_flag && !flag_clear[`FLAG_DONE]); // R16
            write_collision_flag <= write_collision_flag_set || (write_collision_flag && !flag_clear[`FLAG_WRITE_COLLISION_FLAG]); // R17
            mode_fault_flag      <= fault || (mode_fault_flag && !flag_clear[`FLAG_MODE_FAULT_FLAG]); // R15
            receive_overrun_flag <= ovrn_set || (receive_overrun_flag && !flag_clear[`FLAG_OVRN]); // R19
        end
    end

    // =================================================================
    // Status and pin enable
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            transfer_busy_bit <= 1'b0;
            shift_empty       <= 1'b1;
            slave_selected    <= 1'b0;
            miso_oe_n         <= 1'b1;
        end else if (ce) begin
            // Busy follows the counter, so it only rises on a master edge.
            transfer_busy_bit <= port_enable_state && !last_edge &&
                                 (sample_edge || bit_count != `CNT_ZERO || ending); // R22 R5
            shift_empty       <= !(shift_full || direct_load) || master_enable_state;
            slave_selected    <= !sel_s;
            miso_oe_n         <= !active;
        end
    end
endmodule

// ### verif/spi_slave_engine_assertions.sv
// Concurrent checks on the ports of the serial slave engine.
`timescale 1ns/1ps
`include "spi_slave_consts.vh"
module spi_slave_engine_assertions (
    // Clock and reset
    input wire               clk,
    input wire               rstn,
    // Requests
    input wire               ctrl_write,
    input wire               tx_write,
    input wire [`FLAG_W-1:0] flag_clear,
    // Observed state
    input wire               port_enable_state,
    input wire               master_enable_state,
    input wire               rx_valid,
    input wire               byte_done_flag,
    input wire               write_collision_flag,
    input wire               mode_fault_flag,
    input wire               receive_overrun_flag,
    input wire               transfer_busy_bit,
    input wire               shift_empty
);
    // ======
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_done_sticky: assert property (
        byte_done_flag && !flag_clear[`FLAG_DONE] |=> byte_done_flag) else $error("done flag lost");
    a_write_collision_flag_held: assert property (
        $fell(write_collision_flag) |-> $past(flag_clear[`FLAG_WRITE_COLLISION_FLAG])) else $error("collision flag lost");
    a_write_collision_flag_cause: assert property (
        $rose(write_collision_flag) |-> $past(tx_write)) else $error("collision without a write");
    a_mode_fault_flag_disable: assert property (
        $rose(mode_fault_flag) |-> !port_enable_state && !master_enable_state && $past(master_enable_state))
        else $error("mode fault left enables set");
    a_ovrn_full: assert property (
        $rose(receive_overrun_flag) |-> rx_valid) else $error("overrun with empty buffer");
    a_done_stores: assert property (
        $rose(byte_done_flag) |-> ##[0:3] rx_valid) else $error("byte not stored");
    a_done_idle: assert property (
        $rose(byte_done_flag) |-> !transfer_busy_bit) else $error("busy after byte end");
    a_busy_slave: assert property (
        $rose(transfer_busy_bit) |-> port_enable_state && !master_enable_state) else $error("busy while not slave");
    a_load_empty: assert property (
        tx_write && !ctrl_write && shift_empty && !transfer_busy_bit && port_enable_state && !master_enable_state
        |=> !shift_empty) else $error("write not loaded");
endmodule

bind spi_slave_engine spi_slave_engine_assertions chk (
    .clk(clk), .rstn(rstn), .ctrl_write(ctrl_write), .tx_write(tx_write), .flag_clear(flag_clear),
    .port_enable_state(port_enable_state), .master_enable_state(master_enable_state), .rx_valid(rx_valid),
    .byte_done_flag(byte_done_flag), .write_collision_flag(write_collision_flag),
    .mode_fault_flag(mode_fault_flag), .receive_overrun_flag(receive_overrun_flag),
    .transfer_busy_bit(transfer_busy_bit), .shift_empty(shift_empty));

// ### verif/spi_master_model.sv
// Behavioural serial master that clocks frames into the slave engine.
`timescale 1ns/1ps
module spi_master_model (
    // Serial pins
    output logic sck,
    output logic mosi,
    output logic sel_n,
    input  wire  miso
);
    // ======
    // Mode
    logic pol   = 1'b0;
    logic pha   = 1'b0;
    logic three = 1'b0;
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        sel_n = 1'b1;
    end

    // ======
    // Frame of n bits; the clock stands still between frames.
    task automatic frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        sel_n = three;
        #200;
        for (int i = 0; i < n; i++) begin
            if (!pha) mosi = tx[7 - i];
            #100 sck = ~pol;
            if (!pha) rx = {rx[6:0], miso};
            else mosi = tx[7 - i];
            #100 sck = pol;
            if (pha) rx = {rx[6:0], miso};
        end
        #200 sel_n = 1'b1;
        // A released line shows the inverse so stale data cannot pass.
        mosi = ~mosi;
        #200;
    endtask
endmodule

// ### verif/spi_slave_engine_test.sv
// Self-checking bench for the serial slave engine.
`timescale 1ns/1ps
`include "spi_slave_consts.vh"
module spi_slave_engine_test;
    // ======
    // Signals
    logic       clk = 1'b0, rstn = 1'b0, ctrl_write = 1'b0, tx_write = 1'b0, rx_read = 1'b0;
    logic       last_miso = 1'b0;
    logic [5:0] cfg = 6'h00;
    logic [7:0] tx_data = 8'h00, d, r, t, q[$];
    logic [3:0] flag_clear = 4'h0;
    wire        port_enable_state, master_enable_state, rx_valid, byte_done_flag, write_collision_flag;
    wire        mode_fault_flag, receive_overrun_flag, transfer_busy_bit, shift_empty, slave_selected;
    wire        miso_out, miso_oe_n, sck, mosi, sel_n, miso;
    wire  [7:0] rx_data;
    int         fails = 0, samples_checked = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (!miso_oe_n) last_miso <= miso_out;
    assign miso = miso_oe_n ? ~last_miso : miso_out;

    spi_slave_engine uut (.clk(clk), .rstn(rstn), .ce(1'b1), .ctrl_write(ctrl_write),
        .port_enable_bit(cfg[5]), .master_enable_bit(cfg[4]), .clock_phase_bit(cfg[3]),
        .clock_polarity_bit(cfg[2]), .select_mode_upper_bit(cfg[1]), .select_mode_lower_bit(cfg[0]),
        .port_enable_state(port_enable_state), .master_enable_state(master_enable_state),
        .tx_write(tx_write), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .rx_read(rx_read),
        .flag_clear(flag_clear), .byte_done_flag(byte_done_flag), .write_collision_flag(write_collision_flag),
        .mode_fault_flag(mode_fault_flag), .receive_overrun_flag(receive_overrun_flag),
        .transfer_busy_bit(transfer_busy_bit), .shift_empty(shift_empty), .slave_selected(slave_selected),
        .sck(sck), .mosi(mosi), .sel_n(sel_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n));
    spi_master_model m (.sck(sck), .mosi(mosi), .sel_n(sel_n), .miso(miso));

    // ======
    // Tasks
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task ctl(input logic [5:0] v);
        @(posedge clk) ctrl_write <= 1'b1;
        cfg <= v;
        @(posedge clk) ctrl_write <= 1'b0;
        #1;
    endtask
    task wr(input logic [7:0] v);
        @(posedge clk) tx_write <= 1'b1;
        tx_data <= v;
        @(posedge clk) tx_write <= 1'b0;
        #1;
    endtask
    task clr(input logic [3:0] v);
        @(posedge clk) flag_clear <= v;
        @(posedge clk) flag_clear <= 4'h0;
        #1;
    endtask
    task pop_chk(input logic [7:0] e);
        chk(rx_valid, 1'b1);
        chk(rx_data, e);
        @(posedge clk) rx_read <= 1'b1;
        @(posedge clk) rx_read <= 1'b0;
        #1;
    endtask
    // The pin level changes settle before the port is enabled, so no false edge is seen.
    task setup(input logic [1:0] pp, input logic [1:0] md);
        ctl({2'b00, pp, md});
        m.pha = pp[1];
        m.pol = pp[0];
        m.sck = pp[0];
        m.three = (md == `SELMODE_3WIRE);
        repeat (4) @(posedge clk);
        ctl({2'b10, pp, md});
    endtask
    task xf(input logic [7:0] v, output logic [7:0] rv);
        m.frame(v, 8, rv);
        if (q.size() < `FIFO_DEPTH) q.push_back(v);
        @(posedge clk);
        #1;
    endtask
    task tally_and_finish;
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ======
    // Sequence
    initial begin
        void'($urandom(9));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk({byte_done_flag, write_collision_flag, mode_fault_flag, receive_overrun_flag}, 8'h00);
        chk({transfer_busy_bit, shift_empty, miso_oe_n, rx_valid, slave_selected}, 8'h0c);
        for (int k = 0; k < 4; k++) begin
            setup(k[1:0], `SELMODE_4WIRE);
            d = 8'($urandom);
            t = 8'($urandom);
            wr(t);
            chk(shift_empty, 1'b0);
            xf(d, r);
            chk(r, t);
            chk(byte_done_flag, 1'b1);
            pop_chk(q.pop_front());
            clr(4'h1);
            chk(byte_done_flag, 1'b0);
        end
        t = 8'($urandom);
        wr(t);
        wr(~t);
        wr(8'ha5);
        chk(write_collision_flag, 1'b1);
        xf(8'($urandom), r);
        chk(r, t);
        xf(8'($urandom), r);
        chk(r, ~t);
        while (q.size() > 0) pop_chk(q.pop_front());
        clr(4'h3);
        for (int i = 0; i <= `FIFO_DEPTH; i++) begin
            chk(receive_overrun_flag, 1'b0);
            xf(8'($urandom), r);
        end
        chk(receive_overrun_flag, 1'b1);
        while (q.size() > 0) pop_chk(q.pop_front());
        chk(rx_valid, 1'b0);
        clr(4'h9);
        m.frame(8'hff, 3, r);
        chk(byte_done_flag, 1'b0);
        xf(8'($urandom), r);
        pop_chk(q.pop_front());
        setup(2'b00, `SELMODE_3WIRE);
        d = 8'($urandom);
        t = 8'($urandom);
        m.three = 1'b0;
        m.frame(d, 5, r);
        m.three = 1'b1;
        m.frame(t, 3, r);
        pop_chk({d[7:3], t[7:5]});
        m.frame(d, 4, r);
        ctl({2'b00, 2'b00, `SELMODE_3WIRE});
        ctl({2'b10, 2'b00, `SELMODE_3WIRE});
        xf(t, r);
        pop_chk(q.pop_front());
        clr(4'h1);
        setup(2'b00, 2'b10);
        m.frame(d, 8, r);
        chk({byte_done_flag, rx_valid, transfer_busy_bit}, 8'h00);
        ctl({2'b11, 2'b00, `SELMODE_4WIRE});
        m.sel_n = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({mode_fault_flag, port_enable_state, master_enable_state}, 8'h04);
        chk(slave_selected, 1'b1);
        m.sel_n = 1'b1;
        clr(4'h4);
        chk(mode_fault_flag, 1'b0);
        tally_and_finish;
    end

    initial begin
        #400000;
        fails++;
        tally_and_finish;
    end
endmodule
